// ---- rtl/atb_consts.vh ----
// Constants for the acquisition trigger and buffer controller
`ifndef ATB_CONSTS_VH
`define ATB_CONSTS_VH
`define ATB_OFF_CTRL 8'h00
`define ATB_OFF_IN_CFG 8'h04
`define ATB_OFF_OUT_CFG 8'h08
`define ATB_OFF_TRIG_OUT 8'h0C
`define ATB_OFF_THRESH 8'h10
`define ATB_OFF_STATUS 8'h14
`define ATB_OFF_IN_WPTR 8'h18
`define ATB_OFF_OUT_LEN 8'h1C
`define ATB_OFF_OUT_DATA 8'h20
`define ATB_OFF_IN_RDATA 8'h24
`define ATB_OFF_IN_RADDR 8'h28
`define ATB_CTRL_IN_START 0
`define ATB_CTRL_OUT_START 1
`define ATB_CTRL_IN_ABORT 2
`define ATB_CTRL_OUT_ABORT 3
`define ATB_CTRL_OUT_CLEAR 4
`define ATB_CFG_SRC_LSB 0
`define ATB_CFG_IDX_LSB 4
`define ATB_CFG_WRAP 8
`define ATB_TO_BUS_LSB 0
`define ATB_TO_BUS_EN 3
`define ATB_TO_NET_LSB 4
`define ATB_TO_NET_EN 7
`define ATB_SRC_IMMED 3'h0
`define ATB_SRC_EXT 3'h1
`define ATB_SRC_ANALOG 3'h2
`define ATB_SRC_BUS 3'h3
`define ATB_SRC_NET 3'h4
`define ATB_CFG_RST 9'h000
`define ATB_TO_RST 8'h00
`define ATB_THR_MIN_MV 200
`define ATB_THR_MAX_MV 9800
`define ATB_HYST_MV 100
`define ATB_FS_MV 10000
`define ATB_FS_CODES 32768
`endif

// ---- rtl/atb_ctrl.v ----
// Trigger selection, sample buffers and their APB register file
`timescale 1ns/1ns
`include "atb_consts.vh"

////////////////////////////////////////////////////////////////////////////
module atb_fifo #(
  parameter W = 16,
  parameter D = 8,
  parameter AW = 3
) (
  input wire clk, // System clock
  input wire rst_n, // Async reset, active low
  input wire in_valid, // Word offered
  output wire in_ready, // Room for a word
  input wire [W-1:0] in_data, // Word in
  output wire out_valid, // Word available
  input wire out_ready, // Drain takes word
  output wire [W-1:0] out_data // Oldest word
);
  reg [W-1:0] mem [0:D-1];
  reg [AW:0] cnt_q;
  reg [AW-1:0] wp_q;
  reg [AW-1:0] rp_q;
  wire push = in_valid & in_ready;
  wire pop = out_valid & out_ready;
  assign in_ready = (cnt_q != D[AW:0]);
  assign out_valid = (cnt_q != {(AW+1){1'b0}});
  assign out_data = mem[rp_q];
  always @(posedge clk) begin
    if (push) begin
      mem[wp_q] <= in_data;
    end
  end
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q <= {(AW+1){1'b0}};
      wp_q <= {AW{1'b0}};
      rp_q <= {AW{1'b0}};
    end else begin
      if (push) begin
        wp_q <= (wp_q == D[AW-1:0] - 1'b1) ? {AW{1'b0}} : wp_q + 1'b1;
      end
      if (pop) begin
        rp_q <= (rp_q == D[AW-1:0] - 1'b1) ? {AW{1'b0}} : rp_q + 1'b1;
      end
      cnt_q <= cnt_q + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
    end
  end
endmodule // atb_fifo

////////////////////////////////////////////////////////////////////////////
module atb_ctrl #(
  parameter IN_DEPTH = 1024,
  parameter IN_AW = 10,
  parameter OUT_DEPTH = 1024,
  parameter OUT_AW = 10,
  parameter FIFO_DEPTH = 8,
  parameter FIFO_AW = 3
) (
  input wire clk, // System clock, 100 MHz
  input wire rst_n, // Async reset, active low
  input wire psel, // APB select
  input wire penable, // APB access phase
  input wire pwrite, // APB direction
  input wire [7:0] paddr, // APB byte address
  input wire [31:0] pwdata, // APB write data
  output reg [31:0] prdata, // APB read data
  output reg pready, // APB ready
  output reg pslverr, // APB error, unmapped address
  input wire ext_trig_in, // External trigger input
  input wire [5:0] bus_trig_in, // Trigger bus lines, received level
  output reg [5:0] bus_trig_out, // Trigger bus lines, driven level
  output reg [5:0] bus_trig_oe_n, // Trigger bus enables, low drives
  input wire [7:0] net_evt_in, // Network event indications
  output reg net_evt_send, // Broadcast request pulse
  output reg [2:0] net_evt_num, // Broadcast event number
  input wire ain_valid, // Channel one sample strobe
  input wire [15:0] ain_data, // Channel one sample, signed
  input wire dac_tick, // Output update strobe
  output reg dac_valid, // Output value pulse
  output reg [15:0] dac_data, // Output value
  output reg in_trig, // Input start trigger pulse
  output reg out_trig // Output start trigger pulse
);
  localparam integer THR_MIN_I =
    (`ATB_THR_MIN_MV * `ATB_FS_CODES + `ATB_FS_MV - 1) / `ATB_FS_MV;
  localparam integer THR_MAX_I =
    (`ATB_THR_MAX_MV * `ATB_FS_CODES) / `ATB_FS_MV;
  localparam integer HYST_I =
    (`ATB_HYST_MV * `ATB_FS_CODES) / `ATB_FS_MV;
  localparam [15:0] THR_MIN = THR_MIN_I[15:0];
  localparam [15:0] THR_MAX = THR_MAX_I[15:0];
  localparam [15:0] HYST = HYST_I[15:0];
  localparam [2:0] ST_IDLE = 3'h1;
  localparam [2:0] ST_ARMED = 3'h2;
  localparam [2:0] ST_RUN = 3'h4;

  reg [8:0] in_cfg_q;
  reg [8:0] out_cfg_q;
  reg [7:0] to_cfg_q;
  reg [15:0] thr_q;
  reg [IN_AW-1:0] in_raddr_q;
  reg [2:0] in_st_q;
  reg [2:0] out_st_q;
  reg in_done_q;
  reg [IN_AW-1:0] in_wp_q;
  reg [OUT_AW-1:0] out_rp_q;
  reg [OUT_AW:0] out_len_q;
  reg [15:0] in_mem [0:IN_DEPTH-1];
  reg [15:0] out_mem [0:OUT_DEPTH-1];
  reg [14:0] sync1_q;
  reg [14:0] sync2_q;
  reg [14:0] sync3_q;
  reg above_q;
  reg above_d;
  reg ana_pulse_q;
  reg [31:0] rd_d;
  reg map_d;

  // Trigger source decode and threshold clamp helpers
  function hit;
    input [8:0] cfg;
    input start;
    input ext;
    input ana;
    input [5:0] bus;
    input [7:0] net;
    begin
      case (cfg[`ATB_CFG_SRC_LSB +: 3])
        `ATB_SRC_IMMED: hit = start;
        `ATB_SRC_EXT: hit = ext;
        `ATB_SRC_ANALOG: hit = ana;
        `ATB_SRC_BUS: hit = (cfg[`ATB_CFG_IDX_LSB +: 3] < 3'h6) &
          bus[cfg[`ATB_CFG_IDX_LSB +: 3]];
        `ATB_SRC_NET: hit = net[cfg[`ATB_CFG_IDX_LSB +: 3]];
        default: hit = 1'b0;
      endcase
    end
  endfunction

  function [15:0] clamp_thr;
    input [15:0] v;
    begin
      if (v < THR_MIN) begin
        clamp_thr = THR_MIN;
      end else if (v > THR_MAX) begin
        clamp_thr = THR_MAX;
      end else begin
        clamp_thr = v;
      end
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // APB handshake: answer on the second access cycle
  wire acc = psel & penable & ~pready;
  wire fin = psel & penable & pready;
  wire wr = fin & pwrite & ~pslverr;
  wire [2:0] ctl = (wr && paddr == `ATB_OFF_CTRL) ?
    pwdata[2:0] : 3'h0;
  wire out_abort = wr && paddr == `ATB_OFF_CTRL &&
    pwdata[`ATB_CTRL_OUT_ABORT];
  wire in_abort = wr && paddr == `ATB_OFF_CTRL &&
    pwdata[`ATB_CTRL_IN_ABORT];
  wire out_clear = wr && paddr == `ATB_OFF_CTRL &&
    pwdata[`ATB_CTRL_OUT_CLEAR] && out_st_q == ST_IDLE;
  wire in_start = ctl[`ATB_CTRL_IN_START];
  wire out_start = ctl[`ATB_CTRL_OUT_START];
  wire f_in_ready;
  wire f_out_valid;
  wire [15:0] f_out_data;
  wire data_wr = acc & pwrite & (paddr == `ATB_OFF_OUT_DATA);
  wire f_push = wr & (paddr == `ATB_OFF_OUT_DATA);
  // Loading only while output idle and buffer not full
  wire f_pop = f_out_valid & (out_st_q == ST_IDLE) &
    (out_len_q != OUT_DEPTH[OUT_AW:0]) & ~out_clear;

  always @* begin
    rd_d = 32'h0;
    map_d = 1'b1;
    case (paddr)
      `ATB_OFF_CTRL: rd_d = 32'h0;
      `ATB_OFF_IN_CFG: rd_d = {23'h0, in_cfg_q};
      `ATB_OFF_OUT_CFG: rd_d = {23'h0, out_cfg_q};
      `ATB_OFF_TRIG_OUT: rd_d = {24'h0, to_cfg_q};
      `ATB_OFF_THRESH: rd_d = {16'h0, thr_q};
      `ATB_OFF_STATUS: rd_d = {26'h0, above_q, in_done_q, out_st_q[2],
        out_st_q[1], in_st_q[2], in_st_q[1]};
      `ATB_OFF_IN_WPTR: rd_d = {{(32-IN_AW){1'b0}}, in_wp_q};
      `ATB_OFF_OUT_LEN: rd_d = {{(31-OUT_AW){1'b0}}, out_len_q};
      `ATB_OFF_OUT_DATA: rd_d = 32'h0;
      `ATB_OFF_IN_RDATA: rd_d = {16'h0, in_mem[in_raddr_q]};
      `ATB_OFF_IN_RADDR: rd_d = {{(32-IN_AW){1'b0}}, in_raddr_q};
      default: map_d = 1'b0;
    endcase
  end

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0;
    end else begin
      // Back-pressure: a data write waits for FIFO room
      pready <= acc & ~(data_wr & ~f_in_ready);
      pslverr <= acc & ~map_d;
      prdata <= (acc & ~pwrite) ? rd_d : 32'h0;
    end
  end

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      in_cfg_q <= `ATB_CFG_RST;
      out_cfg_q <= `ATB_CFG_RST;
      to_cfg_q <= `ATB_TO_RST;
      thr_q <= THR_MIN;
      in_raddr_q <= {IN_AW{1'b0}};
    end else if (wr) begin
      case (paddr)
        `ATB_OFF_IN_CFG: in_cfg_q <= pwdata[8:0];
        `ATB_OFF_OUT_CFG: out_cfg_q <= pwdata[8:0];
        `ATB_OFF_TRIG_OUT: to_cfg_q <= pwdata[7:0];
        `ATB_OFF_THRESH: thr_q <= clamp_thr(pwdata[15:0]);
        `ATB_OFF_IN_RADDR: in_raddr_q <= pwdata[IN_AW-1:0];
        default: in_raddr_q <= in_raddr_q;
      endcase
    end
  end

  atb_fifo #(
    .W(16),
    .D(FIFO_DEPTH),
    .AW(FIFO_AW)
  ) u_fifo (
    .clk(clk),
    .rst_n(rst_n),
    .in_valid(f_push),
    .in_ready(f_in_ready),
    .in_data(pwdata[15:0]),
    .out_valid(f_out_valid),
    .out_ready(f_pop),
    .out_data(f_out_data)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Trigger inputs: two-stage sync, then rising edge
  wire [14:0] raw = {net_evt_in, bus_trig_in, ext_trig_in};
  wire [14:0] rise = sync2_q & ~sync3_q;
  wire ext_p = rise[0];
  wire [5:0] bus_p = rise[6:1];
  wire [7:0] net_p = rise[14:7];

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sync1_q <= 15'h0;
      sync2_q <= 15'h0;
      sync3_q <= 15'h0;
    end else begin
      sync1_q <= raw;
      sync2_q <= sync1_q;
      sync3_q <= sync2_q;
    end
  end

  // Comparator with hysteresis below the threshold
  always @* begin
    above_d = above_q;
    if (ain_valid) begin
      if (!ain_data[15] && ain_data > thr_q) begin
        above_d = 1'b1;
      end else if (ain_data[15] || ain_data < thr_q - HYST) begin
        above_d = 1'b0;
      end
    end
  end

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      above_q <= 1'b0;
      ana_pulse_q <= 1'b0;
    end else begin
      above_q <= above_d;
      ana_pulse_q <= above_d & ~above_q;
    end
  end

  // Accepted while armed or in the start write cycle itself; immediate fires on the start write
  // A start write while running must not fire again
  wire in_hit = (in_st_q == ST_ARMED ||
    (in_start && in_st_q == ST_IDLE)) &&
    hit(in_cfg_q, in_start, ext_p, ana_pulse_q, bus_p, net_p);
  wire out_hit = (out_st_q == ST_ARMED ||
    (out_start && out_st_q == ST_IDLE)) &&
    hit(out_cfg_q, out_start, ext_p, ana_pulse_q, bus_p, net_p);

  ////////////////////////////////////////////////////////////////////////////
  // Input subsystem
  wire in_last = (in_wp_q == IN_DEPTH[IN_AW-1:0] - 1'b1) |
    (IN_DEPTH == (1 << IN_AW) && &in_wp_q);
  always @(posedge clk) begin
    if (in_st_q == ST_RUN && ain_valid) begin
      in_mem[in_wp_q] <= ain_data;
    end
  end

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      in_st_q <= ST_IDLE;
      in_wp_q <= {IN_AW{1'b0}};
      in_done_q <= 1'b0;
    end else if (in_abort) begin
      in_st_q <= ST_IDLE;
    end else begin
      case (in_st_q)
        ST_IDLE: begin
          if (in_start) begin
            in_st_q <= in_hit ? ST_RUN : ST_ARMED;
            in_wp_q <= {IN_AW{1'b0}};
            in_done_q <= 1'b0;
          end
        end
        ST_ARMED: begin
          if (in_hit) begin
            in_st_q <= ST_RUN;
          end
        end
        ST_RUN: begin
          if (ain_valid) begin
            if (in_last) begin
              in_wp_q <= {IN_AW{1'b0}};
              if (!in_cfg_q[`ATB_CFG_WRAP]) begin
                in_st_q <= ST_IDLE;
                in_done_q <= 1'b1;
              end
            end else begin
              in_wp_q <= in_wp_q + 1'b1;
            end
          end
        end
        default: in_st_q <= ST_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Output subsystem
  wire out_last = ({1'b0, out_rp_q} + 1'b1 >= out_len_q);
  always @(posedge clk) begin
    if (f_pop) begin
      out_mem[out_len_q[OUT_AW-1:0]] <= f_out_data;
    end
  end

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      out_st_q <= ST_IDLE;
      out_rp_q <= {OUT_AW{1'b0}};
      out_len_q <= {(OUT_AW+1){1'b0}};
      dac_valid <= 1'b0;
      dac_data <= 16'h0;
    end else begin
      dac_valid <= 1'b0;
      if (out_clear) begin
        out_len_q <= {(OUT_AW+1){1'b0}};
      end else if (f_pop) begin
        out_len_q <= out_len_q + 1'b1;
      end
      if (out_abort) begin
        out_st_q <= ST_IDLE;
      end else begin
        case (out_st_q)
          ST_IDLE: begin
            if (out_start) begin
              out_st_q <= out_hit ? ST_RUN : ST_ARMED;
              out_rp_q <= {OUT_AW{1'b0}};
            end
          end
          ST_ARMED: begin
            if (out_hit) begin
              out_st_q <= ST_RUN;
            end
          end
          ST_RUN: begin
            if (out_len_q == {(OUT_AW+1){1'b0}}) begin
              out_st_q <= ST_IDLE;
            end else if (dac_tick) begin
              dac_valid <= 1'b1;
              dac_data <= out_mem[out_rp_q];
              if (out_last) begin
                out_rp_q <= {OUT_AW{1'b0}};
                if (!out_cfg_q[`ATB_CFG_WRAP]) begin
                  out_st_q <= ST_IDLE;
                end
              end else begin
                out_rp_q <= out_rp_q + 1'b1;
              end
            end
          end
          default: out_st_q <= ST_IDLE;
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Trigger pulses and broadcast of the input trigger on bus and network
  wire [2:0] bsel = to_cfg_q[`ATB_TO_BUS_LSB +: 3];
  // Abort suppresses the pulse and its broadcast alike
  wire in_go = in_hit & ~in_abort;
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      in_trig <= 1'b0;
      out_trig <= 1'b0;
      bus_trig_out <= 6'h00;
      bus_trig_oe_n <= 6'h3F;
      net_evt_send <= 1'b0;
      net_evt_num <= 3'h0;
    end else begin
      in_trig <= in_go;
      out_trig <= out_hit & ~out_abort;
      bus_trig_out <= 6'h00;
      bus_trig_oe_n <= 6'h3F;
      if (in_go && to_cfg_q[`ATB_TO_BUS_EN] && bsel < 3'h6) begin
        bus_trig_out[bsel] <= 1'b1;
        bus_trig_oe_n[bsel] <= 1'b0;
      end
      net_evt_send <= in_go & to_cfg_q[`ATB_TO_NET_EN];
      net_evt_num <= to_cfg_q[`ATB_TO_NET_LSB +: 3];
    end
  end
endmodule // atb_ctrl

// ---- tb/atb_ctrl_asserts.sv ----
// Port checker for the trigger and buffer controller
`timescale 1ns/1ns
module atb_ctrl_chk (
  input wire clk, // Clock
  input wire rst_n, // Reset, active low
  input wire psel, // APB select
  input wire penable, // APB access
  input wire [31:0] prdata, // Read data
  input wire pready, // Ready
  input wire pslverr, // Error
  input wire [5:0] bus_trig_out, // Bus drive
  input wire [5:0] bus_trig_oe_n, // Bus enables
  input wire net_evt_send, // Broadcast
  input wire dac_tick, // Output tick
  input wire dac_valid, // Output pulse
  input wire in_trig, // Input trigger
  input wire out_trig // Output trigger
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);
  sequence apb_setup;
    psel && !penable;
  endsequence
  sequence apb_access;
    psel && penable;
  endsequence
  apb_answer_a: assert property (apb_setup ##1 apb_access
    |-> ##[1:64] pready) else $error("access not answered");
  ready_pulse_a: assert property (pready |=> !pready)
    else $error("ready longer than one cycle");
  ready_cause_a: assert property (pready |-> $past(psel && penable)
    && psel && penable) else $error("ready without access");
  err_ready_a: assert property (pslverr |-> pready)
    else $error("error without ready");
  rdata_idle_a: assert property (!pready |-> prdata == 32'h0)
    else $error("read data outside answer");
  in_pulse_a: assert property (in_trig |=> !in_trig)
    else $error("input trigger not a pulse");
  out_pulse_a: assert property (out_trig |=> !out_trig)
    else $error("output trigger not a pulse");
  bus_drive_a: assert property (bus_trig_out != 6'h00 |-> in_trig
    && $onehot(bus_trig_out) && bus_trig_oe_n == ~bus_trig_out)
    else $error("bad bus drive");
  bus_release_a: assert property (!in_trig |->
    bus_trig_oe_n == 6'h3F && bus_trig_out == 6'h00)
    else $error("bus not released");
  net_send_a: assert property (net_evt_send |-> in_trig ##1 !net_evt_send)
    else $error("bad broadcast pulse");
  dac_cause_a: assert property (dac_valid |-> $past(dac_tick))
    else $error("output value without tick");
endmodule // atb_ctrl_chk

bind atb_ctrl atb_ctrl_chk u_atb_ctrl_chk (.clk(clk), .rst_n(rst_n),
  .psel(psel), .penable(penable), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .bus_trig_out(bus_trig_out),
  .bus_trig_oe_n(bus_trig_oe_n), .net_evt_send(net_evt_send),
  .dac_tick(dac_tick), .dac_valid(dac_valid), .in_trig(in_trig),
  .out_trig(out_trig));

// ---- tb/atb_peer.sv ----
// Peer instrument on the trigger bus and the network
`timescale 1ns/1ns
module atb_peer (
  input wire clk, // System clock
  input wire [5:0] fire_bus, // Pulse request per bus line
  input wire [7:0] fire_net, // Send request per event
  input wire [5:0] dev_out, // Device bus drive level
  input wire [5:0] dev_oe_n, // Device enables, low drives
  output wire [5:0] bus_lvl, // Resolved bus levels
  output reg [7:0] net_evt // Event indications
);
  reg [5:0] drv_q = 6'h00;
  reg [5:0] bus_d1_q = 6'h00;
  reg [7:0] net_d1_q = 8'h00;
  initial net_evt = 8'h00;
  // Lines pulled low when released
  assign bus_lvl = drv_q | (dev_out & ~dev_oe_n);
  // Two-cycle pulses so the receiver's sync sees them
  always @(posedge clk) begin
    bus_d1_q <= fire_bus;
    drv_q <= fire_bus | bus_d1_q;
    net_d1_q <= fire_net;
    net_evt <= fire_net | net_d1_q;
  end
endmodule // atb_peer

// ---- tb/atb_ctrl_bench.sv ----
// Self-checking bench for the trigger and buffer controller
`timescale 1ns/1ns
module atb_ctrl_bench;
  logic clk = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0;
  logic ext_trig_in = 0, ain_valid = 0, dac_tick = 0;
  logic [7:0] paddr = 0, net_evt, fire_net = 0;
  logic [31:0] pwdata = 0, prdata, rd;
  logic pready, pslverr, net_evt_send, dac_valid, in_trig, out_trig, er;
  logic [5:0] bus_out, bus_oe_n, bus_lvl, fire_bus = 0, cap_bo, cap_oe;
  logic [2:0] net_evt_num, cap_nn;
  logic [15:0] ain_data = 0, dac_data, smp[0:19], val[0:12];
  logic [15:0] dq[$];
  logic cap_ns;
  int errors = 0, compares = 0, cyc = 0, n_in = 0, n_out = 0, b, c;

  initial forever #5 clk = ~clk;

  atb_ctrl #(.IN_DEPTH(16), .IN_AW(4), .OUT_DEPTH(16), .OUT_AW(4))
  u_atb_ctrl (.clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .ext_trig_in(ext_trig_in),
    .bus_trig_in(bus_lvl), .bus_trig_out(bus_out),
    .bus_trig_oe_n(bus_oe_n), .net_evt_in(net_evt),
    .net_evt_send(net_evt_send), .net_evt_num(net_evt_num),
    .ain_valid(ain_valid), .ain_data(ain_data), .dac_tick(dac_tick),
    .dac_valid(dac_valid), .dac_data(dac_data), .in_trig(in_trig),
    .out_trig(out_trig));
  atb_peer u_atb_peer (.clk(clk), .fire_bus(fire_bus),
    .fire_net(fire_net), .dev_out(bus_out), .dev_oe_n(bus_oe_n),
    .bus_lvl(bus_lvl), .net_evt(net_evt));

  ////////////////////////////////////////
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (in_trig === 1'b1) begin
      n_in <= n_in + 1;
      cap_bo <= bus_out;
      cap_oe <= bus_oe_n;
      cap_ns <= net_evt_send;
      cap_nn <= net_evt_num;
    end
    if (out_trig === 1'b1) n_out <= n_out + 1;
    if (dac_valid === 1'b1) dq.push_back(dac_data);
    if (cyc == 20000) begin
      errors = errors + 1;
      complete_run();
    end
  end

  task automatic complete_run();
    if (errors == 0 && compares > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] seen, exp);
    compares++;
    if (seen !== exp) begin
      errors++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic ticks(input int n);
    repeat (n) @(posedge clk);
  endtask

  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rc(input logic [7:0] a, input logic [31:0] m, e,
                    input string nm);
    apb(1'b0, a, 32'h0);
    chk(nm, rd & m, e);
  endtask

  // One event of the given source on the given line or number
  task automatic fire(input int src, input int idx);
    @(posedge clk);
    ext_trig_in <= src == 1;
    fire_bus <= (src == 3) ? 6'h01 << idx : 6'h00;
    fire_net <= (src == 4) ? 8'h01 << idx : 8'h00;
    ain_valid <= src == 2;
    ain_data <= 16'h5000;
    @(posedge clk);
    fire_bus <= 6'h00;
    fire_net <= 8'h00;
    ain_data <= 16'h0000;
    @(posedge clk);
    ext_trig_in <= 1'b0;
    ain_valid <= 1'b0;
  endtask

  // Expected bus drive pattern for a trigger output setting
  function automatic logic [5:0] bus_exp(input logic [7:0] t);
    return t[3] ? 6'h01 << t[2:0] : 6'h00;
  endfunction

  task automatic trig_case(input int src, input int idx);
    logic [7:0] to;
    logic [5:0] eb;
    logic [5:0] en;
    to = 8'($urandom);
    to[2:0] = 3'($urandom_range(5));
    eb = bus_exp(to);
    en = ~eb;
    wr(8'h0C, {24'h0, to});
    wr(8'h00, 32'h4);
    wr(8'h04, 32'(idx * 16 + src));
    b = n_in;
    wr(8'h00, 32'h1);
    repeat (2) begin
      fire(src, idx);
      ticks(6);
      chk("input trigger", n_in - b, 1);
    end
    chk("bus drive", cap_bo, eb);
    chk("bus enable", cap_oe, en);
    chk("net send", cap_ns, to[7]);
    if (to[7]) chk("net event", cap_nn, to[6:4]);
  endtask

  task automatic feed();
    for (int k = 0; k < 20; k++) begin
      @(posedge clk);
      ain_valid <= 1'b1;
      ain_data <= smp[k];
    end
    @(posedge clk);
    ain_valid <= 1'b0;
  endtask

  task automatic tick_dac(input int n);
    dq.delete();
    repeat (n) begin
      @(posedge clk);
      dac_tick <= 1'b1;
      @(posedge clk);
      dac_tick <= 1'b0;
    end
    ticks(3);
  endtask

  ////////////////////////////////////////
  initial begin
    void'($urandom(32'h16f67eb1));
    foreach (smp[k]) smp[k] = 16'($urandom);
    foreach (val[k]) val[k] = 16'($urandom);
    repeat (2) @(posedge clk);
    chk("bus idle", bus_oe_n, 6'h3F);
    rst_n <= 1'b1;
    wr(8'h10, 32'd5);
    rc(8'h10, 32'hFFFF, 32'd656, "threshold floor");
    wr(8'h10, 32'hFFFF);
    rc(8'h10, 32'hFFFF, 32'd32112, "threshold ceiling");
    wr(8'h10, 32'd16000);
    for (int s = 0; s < 5; s++)
      for (int i = 0; i < (s == 3 ? 6 : s == 4 ? 8 : 1); i++)
        trig_case(s, i);
    // Output on the pin, input on bus line 2
    wr(8'h00, 32'hC);
    wr(8'h08, 32'h1);
    wr(8'h04, 32'h23);
    b = n_in;
    c = n_out;
    wr(8'h00, 32'h2);
    wr(8'h00, 32'h1);
    fire(1, 0);
    ticks(6);
    chk("output trigger", n_out - c, 1);
    chk("input trigger", n_in - b, 0);
    fire(3, 2);
    ticks(6);
    chk("input trigger", n_in - b, 1);
    chk("output trigger", n_out - c, 1);
    wr(8'h00, 32'hC);
    wr(8'h04, 32'h0);
    wr(8'h00, 32'h1);
    feed();
    rc(8'h14, 32'h12, 32'h10, "linear status");
    wr(8'h28, 32'h0);
    rc(8'h24, 32'hFFFFFFFF, {16'h0, smp[0]}, "linear word");
    wr(8'h00, 32'h4);
    wr(8'h04, 32'h100);
    wr(8'h00, 32'h1);
    feed();
    rc(8'h14, 32'h2, 32'h2, "circular status");
    rc(8'h18, 32'hFFFFFFFF, 32'h4, "write index");
    rc(8'h24, 32'hFFFFFFFF, {16'h0, smp[16]}, "circular word");
    wr(8'h00, 32'h4);
    rc(8'h30, 32'hFFFFFFFF, 32'h0, "unmapped data");
    chk("unmapped error", er, 1'b1);
    wr(8'h00, 32'h8);
    wr(8'h00, 32'h10);
    for (int k = 0; k < 5; k++) wr(8'h20, {16'h0, val[k]});
    ticks(4);
    rc(8'h1C, 32'hFFFFFFFF, 32'd5, "values loaded");
    wr(8'h08, 32'h0);
    wr(8'h00, 32'h2);
    tick_dac(8);
    chk("linear count", dq.size(), 5);
    for (int k = 0; k < 5; k++) chk("linear out", dq[k], val[k]);
    wr(8'h00, 32'h8);
    wr(8'h08, 32'h100);
    wr(8'h00, 32'h2);
    tick_dac(8);
    chk("wrap count", dq.size(), 8);
    for (int k = 0; k < 8; k++) chk("wrap out", dq[k], val[k % 5]);
    // Fill the FIFO while the output holds it, then let it drain
    for (int k = 5; k < 13; k++) wr(8'h20, {16'h0, val[k]});
    wr(8'h00, 32'h8);
    ticks(12);
    rc(8'h1C, 32'hFFFFFFFF, 32'd13, "values loaded");
    complete_run();
  end
endmodule // atb_ctrl_bench
